// ### fms_defines.svh
// Constants for the fault, lock and soft-start register group.
// Assumes a 250 MHz core clock and an 8-bit register port.
`ifndef FMS_DEFINES_SVH
`define FMS_DEFINES_SVH

// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define FMS_ADDR_WARN_LIMIT  8'h20
`define FMS_ADDR_MASK        8'h22
`define FMS_ADDR_FAULT       8'h23
`define FMS_ADDR_WARNING     8'h24
`define FMS_ADDR_CURRENT     8'h26
`define FMS_ADDR_LOCK        8'h2A
`define FMS_ADDR_RAMP_STAT   8'h2B
`define FMS_ADDR_RAMP_CFG    8'h2C

// --------------------------------------------------------------
// Reset values and field layout
// --------------------------------------------------------------
`define FMS_RST_WARN_LIMIT   8'hFF
`define FMS_RST_MASK         8'h00
`define FMS_RST_CODE         4'h0
`define FMS_ZERO8            8'h00
`define FMS_MASK_USED        8'h7F
`define FMS_BIT_LINE_UV      6
`define FMS_BIT_TEMP_MON     5
`define FMS_BIT_OVER_TEMP    4
`define FMS_BIT_TOTAL_LIMIT  3
`define FMS_BIT_PHASE_LIMIT  2
`define FMS_BIT_OV           1
`define FMS_BIT_UV           0
`define FMS_BIT_LOCK         0
`define FMS_BIT_CURRENT_WARN 0

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define FMS_CLK_NS           4
`define FMS_TICK_NS          10000
`define FMS_TICK_CYC         (`FMS_TICK_NS / `FMS_CLK_NS)
`define FMS_HICCUP_MS        20
`define FMS_HICCUP_CYC       (`FMS_HICCUP_MS * 1000000 / `FMS_CLK_NS)
// Ramp steps in 10 us ticks: short codes, long codes, per reference
`define FMS_RAMP_KNEE        4'h6
`define FMS_STEP_SHORT_1V0   10'h00F
`define FMS_STEP_SHORT_0V8   10'h00C
`define FMS_STEP_LONG_1V0    10'h064
`define FMS_STEP_LONG_0V8    10'h050

`endif

// ### fms_fault_if.sv
// Interface between the register bank and the protection response.
// Assumes both ends share the core clock.
`timescale 1ns/10ps
`default_nettype none
interface fms_fault_if;
  logic [6:0] mask;          // Protection mask register
  logic [6:0] fault;         // Live fault vector, status bit order
  logic       therm_hiccup;  // Over-temperature picks hiccup
  logic       enable;        // External enable input
  logic       latched;       // Regulator latched off
  logic       hiccup;        // Hiccup off-time running
  modport bank (output mask, fault, therm_hiccup, enable, input latched, hiccup);
  modport resp (input mask, fault, therm_hiccup, enable, output latched, hiccup);
endinterface
`default_nettype wire

// ### fms_fault_resp.sv
// Protection response: latch-off and timed hiccup from masked faults.
// Assumes faults arrive synchronous to the core clock.
`timescale 1ns/10ps
`default_nettype none
`include "fms_defines.svh"
module fms_fault_resp #(
  parameter int HICCUP_CYCLES = `FMS_HICCUP_CYC  // Hiccup off-time
) (
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  fms_fault_if.resp  flt
);
  import fms_pkg::*;

  fms_resp_t   state_q;   // Response state
  logic [31:0] hic_cnt_q; // Hiccup off-time count
  logic        latch_evt; // Unmasked latching event
  logic        hic_evt;   // Unmasked hiccup event
  logic        ot_live;   // Unmasked over-temperature

  // ------------------------------------------------------------
  // Masked event decode
  // ------------------------------------------------------------
  always_comb begin
    ot_live   = flt.fault[`FMS_BIT_OVER_TEMP] & ~flt.mask[`FMS_BIT_OVER_TEMP];
    latch_evt =
      (flt.fault[`FMS_BIT_LINE_UV] & ~flt.mask[`FMS_BIT_LINE_UV]) |
      (flt.fault[`FMS_BIT_TEMP_MON] & ~flt.mask[`FMS_BIT_TEMP_MON]) |
      (flt.fault[`FMS_BIT_TOTAL_LIMIT] & ~flt.mask[`FMS_BIT_TOTAL_LIMIT]) |
      (flt.fault[`FMS_BIT_OV] & ~flt.mask[`FMS_BIT_OV]) |
      (flt.fault[`FMS_BIT_UV] & ~flt.mask[`FMS_BIT_UV]) |
      (ot_live & ~flt.therm_hiccup);
    hic_evt = ot_live & flt.therm_hiccup;
  end

  // ------------------------------------------------------------
  // Response state machine
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q   <= FMS_RUN;
      hic_cnt_q <= '0;
    end else begin
      case (state_q)
        FMS_RUN: begin
          hic_cnt_q <= '0;
          if (latch_evt) begin
            state_q <= FMS_LATCHED;
          end else if (hic_evt) begin
            state_q <= FMS_HICCUP;
          end
        end
        FMS_HICCUP: begin
          hic_cnt_q <= hic_cnt_q + 32'h0000_0001;
          if (latch_evt) begin
            state_q <= FMS_LATCHED;
          end else if (hic_cnt_q == 32'(HICCUP_CYCLES - 1)) begin
            state_q <= FMS_RUN;
          end
        end
        FMS_LATCHED: begin
          if (!flt.enable) begin
            state_q <= FMS_RUN;
          end
        end
        default: begin
          state_q <= FMS_LATCHED;
        end
      endcase
    end
  end

  // Status back to the bank
  assign flt.latched = (state_q == FMS_LATCHED);
  assign flt.hiccup  = (state_q == FMS_HICCUP);
endmodule
`default_nettype wire

// ### fms_host_model.sv
// Host side of the register port, as the two-wire logic drives it.
// Assumes one-cycle strobes and read data one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module fms_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // lock and limit writes
  // One strobe at a time
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // Data taken once the registered answer has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ### fms_pkg.sv
// Types shared by the fault, lock and soft-start register group.
// Assumes the constants header is compiled alongside.
package fms_pkg;
  // Ramp time code
  typedef logic [3:0] fms_code_t;
  // Protection response states, Gray along the usual path
  typedef enum logic [1:0] {
    FMS_RUN     = 2'b00,
    FMS_HICCUP  = 2'b01,
    FMS_LATCHED = 2'b11
  } fms_resp_t;
  // Soft-start ramp states
  typedef enum logic [1:0] {
    FMS_R_IDLE = 2'b00,
    FMS_R_RUN  = 2'b01,
    FMS_R_DONE = 2'b11
  } fms_ramp_t;
endpackage

// ### fms_ramp.sv
// Soft-start ramp timer: counts the ramp time chosen by the code.
// Assumes a one-cycle start pulse when the outputs come on.
`timescale 1ns/10ps
`default_nettype none
`include "fms_defines.svh"
module fms_ramp (
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic            i_start,  // Begin a ramp
  input  wire logic            i_abort,  // Outputs dropped
  input  wire fms_pkg::fms_code_t i_code, // Ramp time code
  input  wire logic            i_ref_08, // Reference at 0.8 V
  output logic                 o_active  // Ramp in progress
);
  import fms_pkg::*;

  fms_ramp_t   state_q;  // Ramp state
  logic [11:0] div_q;    // 10 us tick divider
  logic [9:0]  tick_q;   // Elapsed ticks
  logic [9:0]  target;   // Ramp length in ticks
  logic        tick;     // 10 us enable pulse

  // ------------------------------------------------------------
  // Ramp length from the code
  // ------------------------------------------------------------
  // ramp time table
  always_comb begin
    if (i_code < `FMS_RAMP_KNEE) begin
      target = 10'({6'h00, i_code} + 10'h001) *
               (i_ref_08 ? `FMS_STEP_SHORT_0V8 : `FMS_STEP_SHORT_1V0);
    end else begin
      target = 10'({6'h00, i_code} - 10'h005) *
               (i_ref_08 ? `FMS_STEP_LONG_0V8 : `FMS_STEP_LONG_1V0);
    end
  end

  assign tick = (div_q == 12'(`FMS_TICK_CYC - 1));

  // Tick divider, free while ramping
  always_ff @(posedge i_clk) begin
    if (i_rst || state_q != FMS_R_RUN || tick) begin
      div_q <= 12'h000;
    end else begin
      div_q <= div_q + 12'h001;
    end
  end

  // Ramp sequencing
  always_ff @(posedge i_clk) begin
    if (i_rst || i_abort) begin
      state_q  <= FMS_R_IDLE;
      tick_q   <= 10'h000;
      o_active <= 1'b0;
    end else begin
      case (state_q)
        FMS_R_IDLE: begin
          tick_q <= 10'h000;
          if (i_start) begin
            state_q  <= FMS_R_RUN;
            o_active <= 1'b1;
          end
        end
        FMS_R_RUN: begin
          if (tick) begin
            tick_q <= tick_q + 10'h001;
            if (tick_q + 10'h001 >= target) begin
              state_q  <= FMS_R_DONE;
              o_active <= 1'b0;
            end
          end
        end
        FMS_R_DONE: begin
          o_active <= 1'b0;
        end
        default: begin
          state_q <= FMS_R_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### fms_regs.sv
// Fault mask, status, current readback, lock and soft-start registers.
// Assumes a register port driven by the two-wire host logic, with
// one-cycle write and read strobes, and I_RST as the power-on reset.
`timescale 1ns/10ps
`default_nettype none
`include "fms_defines.svh"
module fms_regs #(
  parameter int HICCUP_CYCLES = `FMS_HICCUP_CYC  // Hiccup off-time
) (
  input  wire logic               I_CORE_CLK,
  input  wire logic               I_RST,
  input  wire logic [7:0]         I_REG_ADDR,
  input  wire logic [7:0]         I_REG_WDATA,
  input  wire logic               I_REG_WR,
  input  wire logic               I_REG_RD,
  output logic      [7:0]         O_REG_RDATA,
  input  wire logic               I_LINE_UNDERVOLTAGE,
  input  wire logic               I_TEMP_MONITOR,
  input  wire logic               I_OVER_TEMPERATURE,
  input  wire logic               I_TOTAL_CURRENT_LIMIT,
  input  wire logic               I_PHASE_CURRENT_LIMIT,
  input  wire logic               I_OVERVOLTAGE_PROTECT,
  input  wire logic               I_UNDERVOLTAGE_PROTECT,
  input  wire logic [7:0]         I_CURRENT_MONITOR_CODE,
  input  wire logic               I_ENABLE,
  input  wire fms_pkg::fms_code_t I_STRAP_CODE,
  input  wire logic               I_RAMP_SELECT,
  input  wire logic               I_REF_08V,
  input  wire logic               I_THERM_HICCUP,
  output logic                    O_ALERT,
  output logic                    O_OUTPUT_EN,
  output logic                    O_PHASE_LIMIT_EN,
  output logic                    O_LATCHED_OFF,
  output logic                    O_HICCUP,
  output logic                    O_RAMP_ACTIVE,
  output fms_pkg::fms_code_t      O_RAMP_CODE
);
  import fms_pkg::*;

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (HICCUP_CYCLES < 1) begin : g_bad_hiccup
    $error("HICCUP_CYCLES must be at least one");
  end

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  fms_fault_if flt ();             // Link to the protection response
  logic [7:0]  warn_limit_q;       // Current warning limit
  logic [6:0]  mask_q;             // Protection mask
  logic [6:0]  fault_q;            // Fault status
  logic        warn_q;             // Current warning flag
  logic [7:0]  current_q;          // Current readback
  logic        lock_q;             // Lock bit
  fms_code_t   strap_q;            // Strapped ramp code
  fms_code_t   ramp_cfg_q;         // Programmed ramp code
  fms_code_t   ramp_code;          // Code in use
  logic        por_q;              // First cycle after reset
  logic        en_d;               // Outputs allowed next
  logic        en_q;               // Outputs allowed
  logic        wr_ok;              // Write strobe while lock is clear
  logic        ramp_start;         // Outputs just came on

  // ------------------------------------------------------------
  // Write gating
  // ------------------------------------------------------------
  // lock blocks limit writes
  assign wr_ok = I_REG_WR & ~lock_q;

  // Warning limit register, lockable
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      warn_limit_q <= `FMS_RST_WARN_LIMIT;
    end else if (wr_ok && I_REG_ADDR == `FMS_ADDR_WARN_LIMIT) begin
      warn_limit_q <= I_REG_WDATA;
    end
  end

  // Protection mask register, lockable
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      mask_q <= 7'(`FMS_RST_MASK);
    end else if (wr_ok && I_REG_ADDR == `FMS_ADDR_MASK) begin
      mask_q <= 7'(I_REG_WDATA & `FMS_MASK_USED);
    end
  end

  // Ramp configuration register, lockable
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ramp_cfg_q <= `FMS_RST_CODE;
    end else if (wr_ok && I_REG_ADDR == `FMS_ADDR_RAMP_CFG) begin
      ramp_cfg_q <= I_REG_WDATA[3:0];
    end
  end

  // Lock bit, set-only
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      lock_q <= 1'b0;
    end else if (I_REG_WR && I_REG_ADDR == `FMS_ADDR_LOCK &&
                 I_REG_WDATA[`FMS_BIT_LOCK]) begin
      lock_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Status capture
  // ------------------------------------------------------------
  // Fault status follows the live faults, phase limit only while unmasked
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      fault_q <= 7'h00;
    end else begin
      fault_q[`FMS_BIT_LINE_UV]     <= I_LINE_UNDERVOLTAGE;
      fault_q[`FMS_BIT_TEMP_MON]    <= I_TEMP_MONITOR;
      fault_q[`FMS_BIT_OVER_TEMP]   <= I_OVER_TEMPERATURE;
      fault_q[`FMS_BIT_TOTAL_LIMIT] <= I_TOTAL_CURRENT_LIMIT;
      fault_q[`FMS_BIT_PHASE_LIMIT] <= I_PHASE_CURRENT_LIMIT &
                                       ~mask_q[`FMS_BIT_PHASE_LIMIT];
      fault_q[`FMS_BIT_OV]          <= I_OVERVOLTAGE_PROTECT;
      fault_q[`FMS_BIT_UV]          <= I_UNDERVOLTAGE_PROTECT;
    end
  end

  // Current readback and warning
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      current_q <= `FMS_ZERO8;
      warn_q    <= 1'b0;
      O_ALERT   <= 1'b0;
    end else begin
      current_q <= I_CURRENT_MONITOR_CODE;
      warn_q    <= (I_CURRENT_MONITOR_CODE > warn_limit_q);
      O_ALERT   <= (I_CURRENT_MONITOR_CODE > warn_limit_q);
    end
  end

  // Strap capture on the first cycle after reset
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      por_q   <= 1'b1;
      strap_q <= `FMS_RST_CODE;
    end else if (por_q) begin
      por_q   <= 1'b0;
      strap_q <= I_STRAP_CODE;
    end
  end

  assign ramp_code = I_RAMP_SELECT ? ramp_cfg_q : strap_q;

  // ------------------------------------------------------------
  // Protection response
  // ------------------------------------------------------------
  assign flt.mask         = mask_q;
  assign flt.fault        = fault_q;
  assign flt.therm_hiccup = I_THERM_HICCUP;
  assign flt.enable       = I_ENABLE;

  fms_fault_resp #(
    .HICCUP_CYCLES (HICCUP_CYCLES)
  ) u_resp (
    .i_clk (I_CORE_CLK),
    .i_rst (I_RST),
    .flt   (flt.resp)
  );

  assign en_d       = I_ENABLE & ~flt.latched & ~flt.hiccup & ~por_q;
  assign ramp_start = en_d & ~en_q;

  // Output control flops
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      en_q            <= 1'b0;
      O_OUTPUT_EN     <= 1'b0;
      O_PHASE_LIMIT_EN <= 1'b1;
      O_LATCHED_OFF   <= 1'b0;
      O_HICCUP        <= 1'b0;
      O_RAMP_CODE     <= `FMS_RST_CODE;
    end else begin
      en_q            <= en_d;
      O_OUTPUT_EN     <= en_d;
      O_PHASE_LIMIT_EN <= ~mask_q[`FMS_BIT_PHASE_LIMIT];
      O_LATCHED_OFF   <= flt.latched;
      O_HICCUP        <= flt.hiccup;
      O_RAMP_CODE     <= ramp_code;
    end
  end

  // ------------------------------------------------------------
  // Soft-start ramp
  // ------------------------------------------------------------
  fms_ramp u_ramp (
    .i_clk    (I_CORE_CLK),
    .i_rst    (I_RST),
    .i_start  (ramp_start),
    .i_abort  (~en_d),
    .i_code   (ramp_code),
    .i_ref_08 (I_REF_08V),
    .o_active (O_RAMP_ACTIVE)
  );

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // reserved bits read zero
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_REG_RDATA <= `FMS_ZERO8;
    end else if (I_REG_RD) begin
      case (I_REG_ADDR)
        `FMS_ADDR_WARN_LIMIT: O_REG_RDATA <= warn_limit_q;
        `FMS_ADDR_MASK:       O_REG_RDATA <= {1'b0, mask_q};
        `FMS_ADDR_FAULT:      O_REG_RDATA <= {1'b0, fault_q};
        `FMS_ADDR_WARNING:    O_REG_RDATA <= {7'h00, warn_q};
        `FMS_ADDR_CURRENT:    O_REG_RDATA <= current_q;
        `FMS_ADDR_LOCK:       O_REG_RDATA <= {7'h00, lock_q};
        `FMS_ADDR_RAMP_STAT:  O_REG_RDATA <= {4'h0, strap_q};
        `FMS_ADDR_RAMP_CFG:   O_REG_RDATA <= {4'h0, ramp_cfg_q};
        default:              O_REG_RDATA <= `FMS_ZERO8;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### fms_regs_monitor.sv
// Checker for the fault, lock and soft-start register group.
// Assumes it is bound to fms_regs and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fms_regs_monitor #(
  parameter int HICCUP_CYCLES = 16  // Hiccup off-time
) (
  input wire logic       I_CORE_CLK,
  input wire logic       I_RST,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic       I_REG_WR,
  input wire logic       I_REG_RD,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic       I_LINE_UNDERVOLTAGE,
  input wire logic       I_TEMP_MONITOR,
  input wire logic       I_OVER_TEMPERATURE,
  input wire logic       I_TOTAL_CURRENT_LIMIT,
  input wire logic       I_PHASE_CURRENT_LIMIT,
  input wire logic       I_OVERVOLTAGE_PROTECT,
  input wire logic       I_UNDERVOLTAGE_PROTECT,
  input wire logic [7:0] I_CURRENT_MONITOR_CODE,
  input wire logic       I_ENABLE,
  input wire logic       I_THERM_HICCUP,
  input wire logic       O_ALERT,
  input wire logic       O_OUTPUT_EN,
  input wire logic       O_PHASE_LIMIT_EN,
  input wire logic       O_LATCHED_OFF,
  input wire logic       O_HICCUP,
  input wire logic       O_RAMP_ACTIVE
);
  // ----------------------------------------
  // Helper mirrors
  // ----------------------------------------
  logic [6:0]  msk_q;     // Mask as written
  logic [7:0]  lim_q;     // Warning limit as written
  logic        lck_q;     // Lock as written
  logic [31:0] hic_cnt_q; // Cycles in hiccup
  logic [6:0]  flt;       // Live fault inputs
  logic [6:0]  vis;       // Faults as status shows them
  logic        unm;       // Unmasked latching fault
  logic        over;      // Current above limit
  assign flt = {I_LINE_UNDERVOLTAGE, I_TEMP_MONITOR, I_OVER_TEMPERATURE, I_TOTAL_CURRENT_LIMIT,
                I_PHASE_CURRENT_LIMIT, I_OVERVOLTAGE_PROTECT, I_UNDERVOLTAGE_PROTECT};
  assign vis = {flt[6:3], flt[2] & ~msk_q[2], flt[1:0]};
  assign unm = |(flt & ~msk_q & {2'b11, ~I_THERM_HICCUP, 4'b1011});
  assign over = I_CURRENT_MONITOR_CODE > lim_q;
  // Lockable writes are dropped once locked
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      msk_q <= 7'h00;
      lim_q <= 8'hFF;
      lck_q <= 1'b0;
    end else if (I_REG_WR) begin
      if (!lck_q && I_REG_ADDR == 8'h22) msk_q <= I_REG_WDATA[6:0];
      if (!lck_q && I_REG_ADDR == 8'h20) lim_q <= I_REG_WDATA;
      if (I_REG_ADDR == 8'h2A && I_REG_WDATA[0]) lck_q <= 1'b1;
    end
  end
  // Length of the present hiccup
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || !O_HICCUP) hic_cnt_q <= 32'h0000_0000;
    else hic_cnt_q <= hic_cnt_q + 32'h0000_0001;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  sequence s_rd(logic [7:0] a);
    I_REG_RD && !I_REG_WR && I_REG_ADDR == a;
  endsequence
  property p_latch; unm && I_ENABLE && O_OUTPUT_EN |-> ##[1:4] O_LATCHED_OFF; endproperty
  property p_no_cause;
    $rose(O_LATCHED_OFF) |-> $past(unm, 2) || $past(unm, 3) || $past(unm, 4);
  endproperty
  property p_off; O_LATCHED_OFF || O_HICCUP |-> !O_OUTPUT_EN; endproperty
  property p_plim; $stable(msk_q[2]) [*2] |-> O_PHASE_LIMIT_EN == !msk_q[2]; endproperty
  property p_alert; O_ALERT == $past(over); endproperty
  property p_warn_rd; s_rd(8'h24) |=> O_REG_RDATA == {7'h00, $past(O_ALERT)}; endproperty
  property p_mask_rd; s_rd(8'h22) |=> O_REG_RDATA == {1'b0, $past(msk_q)}; endproperty
  property p_lock_rd; s_rd(8'h2A) |=> O_REG_RDATA == {7'h00, $past(lck_q)}; endproperty
  property p_flt_rd; s_rd(8'h23) |=> O_REG_RDATA == {1'b0, $past(vis, 2)}; endproperty
  property p_ramp; $rose(O_OUTPUT_EN) |-> ##[0:2] O_RAMP_ACTIVE; endproperty
  property p_hic;
    $fell(O_HICCUP) |-> hic_cnt_q + 1 >= HICCUP_CYCLES && hic_cnt_q <= HICCUP_CYCLES + 1;
  endproperty
  a_latch: assert property (p_latch) else $error("unmasked fault not latched");
  a_no_cause: assert property (p_no_cause) else $error("latch without cause");
  a_off: assert property (p_off) else $error("outputs on while off");
  a_plim: assert property (p_plim) else $error("phase limit enable wrong");
  a_alert: assert property (p_alert) else $error("alert wrong");
  a_warn_rd: assert property (p_warn_rd) else $error("warning read wrong");
  a_mask_rd: assert property (p_mask_rd) else $error("mask read wrong");
  a_lock_rd: assert property (p_lock_rd) else $error("lock read wrong");
  a_flt_rd: assert property (p_flt_rd) else $error("fault read wrong");
  a_ramp: assert property (p_ramp) else $error("ramp not started");
  a_hic: assert property (p_hic) else $error("hiccup length wrong");
endmodule
bind fms_regs fms_regs_monitor #(.HICCUP_CYCLES(HICCUP_CYCLES)) fms_regs_monitor_i (.*);
`default_nettype wire

// ### tb_top.sv
// Testbench for the fault, lock and soft-start register group.
// Assumes the host model drives the register port.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fms_pkg::*;
  localparam int HIC = 16;           // Short hiccup
  localparam int RAMP0 = 150000 / 4; // Code 0 ramp in cycles
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr, wdata, rdata, d;
  logic       wr, rd, alert, oen, pil, lat, hic, ract;
  logic [7:0] code = 8'h00;
  logic [6:0] flt = 7'h00;
  logic       en = 1'b1;
  logic       sel = 1'b0;
  logic       therm = 1'b0;
  logic [3:0] strap = 4'h0;
  fms_code_t  rcode;
  int         err_count = 0;
  int         comparisons = 0;
  int         cyc = 0;
  fms_host_model fms_host_model_i (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  fms_regs #(.HICCUP_CYCLES(HIC)) fms_regs_i (.I_CORE_CLK(clk), .I_RST(rst),
    .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd),
    .O_REG_RDATA(rdata), .I_LINE_UNDERVOLTAGE(flt[6]), .I_TEMP_MONITOR(flt[5]),
    .I_OVER_TEMPERATURE(flt[4]), .I_TOTAL_CURRENT_LIMIT(flt[3]),
    .I_PHASE_CURRENT_LIMIT(flt[2]), .I_OVERVOLTAGE_PROTECT(flt[1]),
    .I_UNDERVOLTAGE_PROTECT(flt[0]), .I_CURRENT_MONITOR_CODE(code), .I_ENABLE(en),
    .I_STRAP_CODE(strap), .I_RAMP_SELECT(sel), .I_REF_08V(1'b0), .I_THERM_HICCUP(therm),
    .O_ALERT(alert), .O_OUTPUT_EN(oen), .O_PHASE_LIMIT_EN(pil), .O_LATCHED_OFF(lat),
    .O_HICCUP(hic), .O_RAMP_ACTIVE(ract), .O_RAMP_CODE(rcode));
  always #2 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      complete_run;
    end
  end
  task automatic complete_run;
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR time=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    fms_host_model_i.rd(a, d);
    chk(d, exp);
  endtask
  task automatic tog_en;
    en <= 1'b0;
    tk(4);
    en <= 1'b1;
    tk(4);
  endtask
  // Power-on ramp length for strap code 0
  task automatic t_ramp;
    int n;
    for (n = 0; n < 20 && ract !== 1'b1; n++) tk(1);
    for (n = 0; n < 40000 && ract === 1'b1; n++) tk(1);
    chk(n > RAMP0 - 3 && n < RAMP0 + 3, 1'b1);
  endtask
  task automatic t_reset;
    rdc(8'h22, 8'h00);
    rdc(8'h20, 8'hFF);
    rdc(8'h2B, 8'h00);
    rdc(8'h25, 8'h00);
  endtask
  task automatic t_phase;
    fms_host_model_i.wr(8'h22, 8'h04);
    flt <= 7'h04;
    tk(3);
    chk(pil, 1'b0);
    rdc(8'h23, 8'h00);
    fms_host_model_i.wr(8'h22, 8'h00);
    tk(3);
    chk(pil, 1'b1);
    rdc(8'h23, 8'h04);
    flt <= 7'h00;
  endtask
  // Each latching fault masked, then unmasked
  task automatic t_mask;
    for (int b = 0; b < 7; b++) begin
      if (b != 2) begin
        fms_host_model_i.wr(8'h22, 8'(1 << b));
        flt <= 7'(1 << b);
        tk(4);
        chk(lat, 1'b0);
        rdc(8'h23, 8'(1 << b));
        flt <= 7'h00;
        fms_host_model_i.wr(8'h22, 8'h00);
        flt <= 7'(1 << b);
        tk(4);
        chk(lat, 1'b1);
        chk(oen, 1'b0);
        flt <= 7'h00;
        tog_en;
        chk(lat, 1'b0);
        chk(oen, 1'b1);
      end
    end
  endtask
  task automatic t_hiccup;
    therm <= 1'b1;
    flt <= 7'h10;
    tk(2);
    flt <= 7'h00;
    tk(3);
    chk(hic, 1'b1);
    chk(lat, 1'b0);
    tk(HIC + 6);
    chk(hic, 1'b0);
    fms_host_model_i.wr(8'h22, 8'h10);
    flt <= 7'h10;
    tk(4);
    chk(hic, 1'b0);
    flt <= 7'h00;
    fms_host_model_i.wr(8'h22, 8'h00);
    therm <= 1'b0;
  endtask
  // Limit edge: equal is quiet, one above warns
  task automatic t_warn;
    fms_host_model_i.wr(8'h20, 8'h80);
    code <= 8'h80;
    tk(3);
    chk(alert, 1'b0);
    rdc(8'h24, 8'h00);
    code <= 8'h81;
    tk(3);
    chk(alert, 1'b1);
    rdc(8'h24, 8'h01);
    rdc(8'h26, 8'h81);
  endtask
  task automatic t_cfg;
    fms_host_model_i.wr(8'h2C, 8'hF5);
    rdc(8'h2C, 8'h05);
    sel <= 1'b1;
    tog_en;
    chk(rcode, 4'h5);
    sel <= 1'b0;
    tog_en;
    chk(rcode, 4'h0);
  endtask
  // Lock, blocked writes, then power-on reset
  task automatic t_lock;
    fms_host_model_i.wr(8'h2A, 8'h03);
    rdc(8'h2A, 8'h01);
    fms_host_model_i.wr(8'h22, 8'h7F);
    rdc(8'h22, 8'h00);
    fms_host_model_i.wr(8'h2C, 8'h0A);
    rdc(8'h2C, 8'h05);
    fms_host_model_i.wr(8'h20, 8'h00);
    rdc(8'h20, 8'h80);
    fms_host_model_i.wr(8'h2A, 8'h00);
    rdc(8'h2A, 8'h01);
    strap <= 4'h9;
    rst <= 1'b1;
    tk(2);
    rst <= 1'b0;
    rdc(8'h2A, 8'h00);
    rdc(8'h2B, 8'h09);
    chk(rcode, 8'h09);
  endtask
  initial begin
    tk(2);
    rst <= 1'b0;
    t_ramp;
    t_reset;
    t_phase;
    t_mask;
    t_hiccup;
    t_warn;
    t_cfg;
    t_lock;
    complete_run;
  end
endmodule
`default_nettype wire
